// ==== include/cpes_consts.vh ====
// constants for the position / edge-separation counter channel
// assumes a 32-bit avalon-mm register port with byte addresses
`ifndef CPES_CONSTS_VH
`define CPES_CONSTS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CPES_ADDR_CTRL    5'h00
`define CPES_ADDR_RELOAD  5'h04
`define CPES_ADDR_COUNT   5'h08
`define CPES_ADDR_STATUS  5'h0c
`define CPES_ADDR_FIFO    5'h10
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CPES_C_MODE_HI    2
`define CPES_C_MODE_LO    0
`define CPES_C_ARM        3
`define CPES_C_SAMP_EN    4
`define CPES_C_TSP        5
`define CPES_C_Z_EN       6
`define CPES_C_ZPH_HI     8
`define CPES_C_ZPH_LO     7
`define CPES_C_GATE_FALL  9
`define CPES_C_AUX_FALL   10
`define CPES_C_SRC_FALL   11
`define CPES_C_SAMP_FALL  12
`define CPES_C_DMA_EN     13
`define CPES_CTRL_MASK    32'h00003fff
`define CPES_CTRL_RST     32'h00000000
`define CPES_RELOAD_RST   32'h00000000
// ------------------------------------------------------------
// modes
// ------------------------------------------------------------
`define CPES_M_IDLE       3'h0
`define CPES_M_X1         3'h1
`define CPES_M_X2         3'h2
`define CPES_M_X4         3'h3
`define CPES_M_TWOP       3'h4
`define CPES_M_SEP_ONE    3'h5
`define CPES_M_SEP_IMP    3'h6
`define CPES_M_SEP_SMP    3'h7
// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define CPES_S_OVR        0
`define CPES_S_FOVF       1
`define CPES_S_EMPTY      2
`define CPES_S_FULL       3
`define CPES_S_LVL_LO     4
`define CPES_S_ST_LO      8
// ------------------------------------------------------------
// fifo
// ------------------------------------------------------------
`define CPES_FIFO_AW      3
`define CPES_FIFO_DEPTH   4'h8
`define CPES_ZERO32       32'h00000000
`define CPES_ONE32        32'h00000001
`endif

// ==== src/cpes_counter.v ====
// position / edge-separation counter channel with avalon-mm registers
// assumes only the bus pins and i_dma_ready are synchronous to i_mclk, the others are synchronised; the timebase input
// i_src is sampled, so it must be well below half the clock rate
`timescale 1ns/1ns
`default_nettype none
`include "cpes_consts.vh"

// Notes on behaviour
// - up when a leads, down when b leads
// - x1: one count per cycle on a
// - x2: count on both a edges
// - x4: count on every a and b edge
// - index high in chosen phase reloads count
// - count edge first, reload afterwards
// - reload within one clock of phase true
// - keep counting normally after reload
// - two-pulse: a rise up, b rise down
// - sampled position: cumulative captures, no reset
// - gate is sample clock, edge selectable
// - captured values go out on dma path
// - aux edge starts interval, later aux ignored
// - gate edge stops, count stored in fifo
// - aux and gate polarity chosen separately
// - timebase counted on rising or falling edge
// - single mode without tsp ignores edges after one result
// - implicit mode restarts on next gate edge
// - sampled mode stores result on sample edge
// - no complete pair between samples: overrun
module cpes_counter (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire [4:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output wire [31:0] o_avs_readdata,
    output wire        o_avs_waitrequest,
    input  wire        i_enc_a,
    input  wire        i_enc_b,
    input  wire        i_enc_z,
    input  wire        i_aux,
    input  wire        i_gate,
    input  wire        i_src,
    input  wire        i_samp_clk,
    output wire        o_dma_valid,
    output wire [31:0] o_dma_data,
    input  wire        i_dma_ready,
    output wire        o_overrun
);

// ------------------------------------------------------------
// separation states
// ------------------------------------------------------------
localparam [4:0] ST_IDLE  = 5'h01;
localparam [4:0] ST_START = 5'h02;
localparam [4:0] ST_COUNT = 5'h04;
localparam [4:0] ST_HELD  = 5'h08;
localparam [4:0] ST_REGAT = 5'h10;

reg  [31:0] ctrl_q;
reg  [31:0] reload_q;
reg  [31:0] count_q;
reg  [31:0] count_d;
reg  [31:0] result_q;
reg  [4:0]  st_q;
reg  [4:0]  st_d;
reg         ovr_q;
reg         fovf_q;
reg         ack_q;
reg  [31:0] rdata_q;
reg  [5:0]  s1_q;
reg  [5:0]  s2_q;
reg  [5:0]  s3_q;
reg  [31:0] mem [0:7];
reg  [2:0]  wp_q;
reg  [2:0]  rp_q;
reg  [3:0]  lvl_q;
reg         push;
reg  [31:0] push_data;
reg         ovr_set;
reg         z_pend_q;

wire [2:0] mode      = ctrl_q[`CPES_C_MODE_HI:`CPES_C_MODE_LO];
wire       armed     = ctrl_q[`CPES_C_ARM];
wire       is_quad   = (mode == `CPES_M_X1) || (mode == `CPES_M_X2) || (mode == `CPES_M_X4);
wire       is_pos    = is_quad || (mode == `CPES_M_TWOP);
wire       is_sep    = (mode == `CPES_M_SEP_ONE) || (mode == `CPES_M_SEP_IMP) || (mode == `CPES_M_SEP_SMP);
wire       sep_smp   = (mode == `CPES_M_SEP_SMP) || ctrl_q[`CPES_C_TSP];

// ------------------------------------------------------------
// input synchronisers and edge strobes
// ------------------------------------------------------------
// order: a, b, z, aux, gate, src ; samp clock kept apart below
reg  [1:0] sc_q;
reg        sc3_q;
always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        s1_q  <= 6'h00;
        s2_q  <= 6'h00;
        s3_q  <= 6'h00;
        sc_q  <= 2'h0;
        sc3_q <= 1'b0;
    end else begin
        s1_q  <= {i_src, i_gate, i_aux, i_enc_z, i_enc_b, i_enc_a};
        s2_q  <= s1_q;
        s3_q  <= s2_q;
        sc_q  <= {sc_q[0], i_samp_clk};
        sc3_q <= sc_q[1];
    end
end

wire a_now  = s2_q[0];
wire b_now  = s2_q[1];
wire a_prev = s3_q[0];
wire b_prev = s3_q[1];
wire z_now  = s2_q[2];
wire [5:0] rise = s2_q & ~s3_q;
wire [5:0] fall = ~s2_q & s3_q;
// polarity selects pick the active edge per input
wire aux_ev  = ctrl_q[`CPES_C_AUX_FALL]  ? fall[3] : rise[3];
wire gate_ev = ctrl_q[`CPES_C_GATE_FALL] ? fall[4] : rise[4];
wire src_ev  = ctrl_q[`CPES_C_SRC_FALL]  ? fall[5] : rise[5];
wire smp_ev  = ctrl_q[`CPES_C_SAMP_FALL] ? (~sc_q[1] & sc3_q) : (sc_q[1] & ~sc3_q);

// ------------------------------------------------------------
// quadrature and two-pulse decode
// ------------------------------------------------------------
// up steps follow 00->10->11->01->00 in {a,b}, i.e. a leading
wire [3:0] tr = {a_prev, b_prev, a_now, b_now};
wire q_up = (tr == 4'h2) || (tr == 4'hb) || (tr == 4'hd) || (tr == 4'h4);
wire q_dn = (tr == 4'h1) || (tr == 4'h7) || (tr == 4'he) || (tr == 4'h8);
wire a_chg = a_now ^ a_prev;
reg  inc;
reg  dec;

// per-mode selection of which transitions count
always @* begin
    inc = 1'b0;
    dec = 1'b0;
    case (mode)
        `CPES_M_X1: begin
            inc = q_up && rise[0] && !b_now;
            dec = q_dn && fall[0] && !b_now;
        end
        `CPES_M_X2: begin
            inc = q_up && a_chg;
            dec = q_dn && a_chg;
        end
        `CPES_M_X4: begin
            inc = q_up;
            dec = q_dn;
        end
        `CPES_M_TWOP: begin
            // both rising together cancel out
            inc = rise[0] && !rise[1];
            dec = rise[1] && !rise[0];
        end
        default: begin
            inc = 1'b0;
            dec = 1'b0;
        end
    endcase
end

// index reload: phase is the {a,b} level pair chosen by software
wire z_phase  = ({a_now, b_now} == ctrl_q[`CPES_C_ZPH_HI:`CPES_C_ZPH_LO]);
wire z_hit    = is_quad && ctrl_q[`CPES_C_Z_EN] && z_phase && z_now;
wire step     = inc || dec;
// a reload that meets a count edge is deferred one clock, so the
// step lands first and the reload follows on the next clock
wire do_load  = (z_hit && !step) || (z_pend_q && z_hit);

// ------------------------------------------------------------
// avalon-mm slave
// ------------------------------------------------------------
// fixed one wait state: data is registered on the first cycle
wire req     = i_avs_read || i_avs_write;
wire acc     = req && ack_q;
wire wr_acc  = i_avs_write && ack_q;
wire rd_fifo = i_avs_read && ack_q && (i_avs_address == `CPES_ADDR_FIFO);
wire [31:0] ctrl_wr = i_avs_writedata & `CPES_CTRL_MASK;
wire ctrl_wr_en = wr_acc && (i_avs_address == `CPES_ADDR_CTRL);
wire arm_rise   = ctrl_wr_en && ctrl_wr[`CPES_C_ARM] && !armed;
wire st_clr     = wr_acc && (i_avs_address == `CPES_ADDR_STATUS);

assign o_avs_waitrequest = req && !ack_q;
assign o_avs_readdata    = rdata_q;
assign o_overrun         = ovr_q;

wire fifo_empty = (lvl_q == 4'h0);
wire fifo_full  = (lvl_q == `CPES_FIFO_DEPTH);
wire dma_en     = ctrl_q[`CPES_C_DMA_EN];
wire pop_dma    = dma_en && !fifo_empty && i_dma_ready;
wire pop_sw     = !dma_en && rd_fifo && !fifo_empty;
wire pop        = pop_dma || pop_sw;

// read mux, sampled one cycle before the access completes
always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        ack_q   <= 1'b0;
        rdata_q <= `CPES_ZERO32;
    end else begin
        ack_q <= req && !ack_q;
        if (i_avs_read && !ack_q) begin
            case (i_avs_address)
                `CPES_ADDR_CTRL:   rdata_q <= ctrl_q;
                `CPES_ADDR_RELOAD: rdata_q <= reload_q;
                `CPES_ADDR_COUNT:  rdata_q <= count_q;
                `CPES_ADDR_STATUS: rdata_q <= {19'h00000, st_q, lvl_q, fifo_full,
                                               fifo_empty, fovf_q, ovr_q};
                `CPES_ADDR_FIFO:   rdata_q <= fifo_empty ? `CPES_ZERO32 : mem[rp_q];
                default:           rdata_q <= `CPES_ZERO32;
            endcase
        end
    end
end

// control and reload registers
always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        ctrl_q   <= `CPES_CTRL_RST;
        reload_q <= `CPES_RELOAD_RST;
    end else begin
        if (ctrl_wr_en) begin
            ctrl_q <= ctrl_wr;
        end
        if (wr_acc && (i_avs_address == `CPES_ADDR_RELOAD)) begin
            reload_q <= i_avs_writedata;
        end
    end
end

// ------------------------------------------------------------
// separation sequencer and capture
// ------------------------------------------------------------
always @* begin
    st_d      = st_q;
    count_d   = count_q;
    push      = 1'b0;
    push_data = count_q;
    ovr_set   = 1'b0;
    if (is_pos && armed) begin
        if (inc) begin
            count_d = count_q + `CPES_ONE32;
        end else if (dec) begin
            count_d = count_q - `CPES_ONE32;
        end
        if (do_load) begin
            count_d = reload_q;
        end
        // captures never disturb the running count
        if (ctrl_q[`CPES_C_SAMP_EN] && gate_ev) begin
            push      = 1'b1;
            push_data = count_q;
        end
    end else if (is_sep && armed) begin
        case (st_q)
            ST_START: begin
                if (aux_ev) begin
                    st_d    = ST_COUNT;
                    count_d = `CPES_ZERO32;
                end
            end
            ST_COUNT: begin
                // aux is not looked at here, extra starts are ignored
                if (gate_ev) begin
                    if (sep_smp) begin
                        st_d = ST_HELD;
                    end else begin
                        push = 1'b1;
                        st_d = (mode == `CPES_M_SEP_ONE) ? ST_IDLE : ST_REGAT;
                    end
                end else if (src_ev) begin
                    count_d = count_q + `CPES_ONE32;
                end
            end
            ST_HELD: begin
                if (smp_ev) begin
                    push = 1'b1;
                    st_d = ST_REGAT;
                end
            end
            ST_REGAT: begin
                if (gate_ev) begin
                    st_d = ST_START;
                end
            end
            default: begin
                st_d = st_q; // idle: all edges ignored
            end
        endcase
        // a sample with no finished pair pending is an overrun
        if (sep_smp && smp_ev && (st_q != ST_HELD)) begin
            ovr_set = 1'b1;
        end
    end
    if (arm_rise) begin
        count_d = `CPES_ZERO32;
        st_d    = ST_START;
    end else if (!armed) begin
        st_d = ST_IDLE;
    end
end

always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        st_q     <= ST_IDLE;
        count_q  <= `CPES_ZERO32;
        result_q <= `CPES_ZERO32;
        z_pend_q <= 1'b0;
    end else begin
        st_q     <= st_d;
        count_q  <= count_d;
        z_pend_q <= z_hit && step;
        if (push) begin
            result_q <= push_data;
        end
    end
end

// ------------------------------------------------------------
// result fifo and dma stream
// ------------------------------------------------------------
// a push into a full fifo is dropped and flagged unless a pop frees a slot that cycle; the dma side
// must keep up, software sees the loss in the status register
wire do_push = push && (!fifo_full || pop);
always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        wp_q  <= 3'h0;
        rp_q  <= 3'h0;
        lvl_q <= 4'h0;
    end else begin
        if (do_push) begin
            wp_q <= wp_q + 3'h1;
        end
        if (pop) begin
            rp_q <= rp_q + 3'h1;
        end
        if (do_push && !pop) begin
            lvl_q <= lvl_q + 4'h1;
        end else if (pop && !do_push) begin
            lvl_q <= lvl_q - 4'h1;
        end
    end
end

// storage has no reset, only the pointers and the level count do
always @(posedge i_mclk) begin
    if (do_push) begin
        mem[wp_q] <= push_data;
    end
end

assign o_dma_valid = dma_en && !fifo_empty;
assign o_dma_data  = mem[rp_q];

// sticky flags: a new event in the clearing cycle wins
always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        ovr_q  <= 1'b0;
        fovf_q <= 1'b0;
    end else begin
        if (ovr_set) begin
            ovr_q <= 1'b1;
        end else if (st_clr && i_avs_writedata[`CPES_S_OVR]) begin
            ovr_q <= 1'b0;
        end
        if (push && fifo_full && !pop) begin
            fovf_q <= 1'b1;
        end else if (st_clr && i_avs_writedata[`CPES_S_FOVF]) begin
            fovf_q <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// ==== dv/cpes_enc_model.sv ====
// encoder model: quadrature or two-pulse a/b plus index
// stepped by the bench, one clock pulse per state change
`timescale 1ns/1ns
`default_nettype none
// ----------
// encoder model
// ----------
module cpes_enc_model (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_step,
    input  wire logic       i_dir,
    input  wire logic       i_twop,
    input  wire logic       i_zen,
    input  wire logic [1:0] i_zph,
    output var  logic       o_a,
    output var  logic       o_b,
    output wire logic       o_z
);
    // gray step forward 00-10-11-01; two-pulse toggles one line
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_a <= 1'b0;
            o_b <= 1'b0;
        end else if (i_step && i_twop) begin
            if (i_dir) o_a <= !o_a;
            else o_b <= !o_b;
        end else if (i_step) begin
            o_a <= i_dir ? !o_b : o_b;
            o_b <= i_dir ? o_a : !o_a;
        end
    end
    // index held high for the whole chosen phase
    assign o_z = i_zen && ({o_a, o_b} == i_zph);
endmodule
`default_nettype wire

// ==== dv/cpes_props.sv ====
// port checker for the counter channel
// bound to cpes_counter; one clock domain
`timescale 1ns/1ns
`default_nettype none
`include "cpes_consts.vh"
// ----------
// checker
// ----------
module cpes_props (
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic [4:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_gate,
    input wire logic        i_samp_clk,
    input wire logic        o_dma_valid,
    input wire logic [31:0] o_dma_data,
    input wire logic        i_dma_ready,
    input wire logic        o_overrun
);
    logic [5:0] sh_q;
    logic [5:0] gh_q;
    logic       st_wr;
    logic       ct_wr;
    logic       quiet;
    // pin history; six samples cover the synchroniser delay
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_q <= 6'h00;
            gh_q <= 6'h00;
        end else begin
            sh_q <= {sh_q[4:0], i_samp_clk};
            gh_q <= {gh_q[4:0], i_gate};
        end
    end
    // decoded writes and a quiet sample clock
    assign st_wr = i_avs_write && i_avs_address == `CPES_ADDR_STATUS;
    assign ct_wr = i_avs_write && i_avs_address == `CPES_ADDR_CTRL;
    assign quiet = (sh_q == 6'h00 && !i_samp_clk) || (sh_q == 6'h3f && i_samp_clk);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_wait_first;
        $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("bus wait state wrong");
    property p_ctrl_mask;
        i_avs_read && !o_avs_waitrequest && i_avs_address == `CPES_ADDR_CTRL |-> o_avs_readdata[31:14] == 18'h0;
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask) else $error("ctrl high bits set");
    property p_unmapped;
        i_avs_read && !o_avs_waitrequest && (i_avs_address > 5'h10 || i_avs_address[1:0] != 2'h0)
            |-> o_avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_dma_hold;
        o_dma_valid && !i_dma_ready && !ct_wr |=> o_dma_valid && $stable(o_dma_data);
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma word not held");
    property p_dma_cause;
        $rose(o_dma_valid) |-> $past(ct_wr) || (gh_q != 6'h00 && gh_q != 6'h3f) || !quiet;
    endproperty
    a_dma_cause: assert property (p_dma_cause) else $error("push without edge");
    property p_ovr_sticky;
        o_overrun && !st_wr |=> o_overrun;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun dropped");
    property p_ovr_cause;
        $rose(o_overrun) |-> !quiet;
    endproperty
    a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without sample");
    property p_ovr_clear;
        st_wr && i_avs_writedata[0] && !o_avs_waitrequest && quiet |=> !o_overrun;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");
    c_ovr: cover property ($rose(o_overrun));
    c_pop: cover property (o_dma_valid && i_dma_ready);
    c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule
bind cpes_counter cpes_props cpes_props_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_gate(i_gate), .i_samp_clk(i_samp_clk),
    .o_dma_valid(o_dma_valid), .o_dma_data(o_dma_data), .i_dma_ready(i_dma_ready),
    .o_overrun(o_overrun));
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the counter channel
// drives the register bus, encoder model, pins and dma ready
`timescale 1ns/1ns
`default_nettype none
`include "cpes_consts.vh"
// ----------
// bench
// ----------
module testbench;
    logic        i_mclk, i_rst_n, rd, wr, st, dr, twop, zen, rdy;
    logic [4:0]  adr;
    logic [31:0] wd;
    logic [1:0]  zph;
    logic [3:0]  pin;
    wire logic   wt, a, b, z, dv, ovr;
    wire logic [31:0] rdat, ddat;
    int          err_total, check_count;
    cpes_counter cpes_counter_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_enc_a(a), .i_enc_b(b), .i_enc_z(z), .i_aux(pin[0]),
        .i_gate(pin[1]), .i_src(pin[2]), .i_samp_clk(pin[3]), .o_dma_valid(dv),
        .o_dma_data(ddat), .i_dma_ready(rdy), .o_overrun(ovr));
    cpes_enc_model cpes_enc_model_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_step(st),
        .i_dir(dr), .i_twop(twop), .i_zen(zen), .i_zph(zph), .o_a(a), .o_b(b), .o_z(z));
    // free-running 50 mhz clock
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // request held until waitrequest is seen low at a rising edge;
    // read data taken and request dropped at that same edge
    task bus(input logic w, input logic [4:0] ad, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge i_mclk);
        rd <= !w;
        wr <= w;
        adr <= ad;
        wd <= d;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (wt !== 1'b0 && n < 20);
        if (n >= 20) begin
            err_total++;
            close_out;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task wrr(input logic [4:0] ad, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ad, d, q);
    endtask
    task rck(input logic [4:0] ad, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, ad, 32'h0, q);
        chk(q, e);
    endtask
    task arm(input logic [31:0] c);
        wrr(`CPES_ADDR_CTRL, 32'h0);
        wrr(`CPES_ADDR_CTRL, c | 32'h8);
    endtask
    // one encoder state change; count lands three edges later
    task step(input logic d);
        @(posedge i_mclk);
        st <= 1'b1;
        dr <= d;
        @(posedge i_mclk);
        st <= 1'b0;
        repeat (6) @(posedge i_mclk);
    endtask
    // pulse one pin: 0 aux, 1 gate, 2 src, 3 sample clock
    task tick(input int i);
        @(posedge i_mclk);
        pin[i] <= 1'b1;
        repeat (3) @(posedge i_mclk);
        pin[i] <= 1'b0;
        repeat (4) @(posedge i_mclk);
    endtask
    task t_regs;
        rck(`CPES_ADDR_CTRL, 32'h0);
        rck(`CPES_ADDR_STATUS, 32'h104);
        rck(5'h14, 32'h0);
        wrr(`CPES_ADDR_RELOAD, 32'h12345678);
        rck(`CPES_ADDR_RELOAD, 32'h12345678);
        wrr(`CPES_ADDR_CTRL, 32'hffffffff);
        rck(`CPES_ADDR_CTRL, 32'h3fff);
        wrr(`CPES_ADDR_COUNT, 32'h5);
        rck(`CPES_ADDR_COUNT, 32'h0);
    endtask
    task t_quad;
        int m, j;
        for (m = 1; m <= 3; m++) begin
            arm(m);
            for (j = 0; j < 4; j++) step(1'b1);
            rck(`CPES_ADDR_COUNT, (m == 3) ? 4 : m);
            for (j = 0; j < 4; j++) step(1'b0);
            rck(`CPES_ADDR_COUNT, 32'h0);
        end
        twop <= 1'b1;
        arm(4);
        for (j = 0; j < 4; j++) step(1'b1);
        for (j = 0; j < 2; j++) step(1'b0);
        rck(`CPES_ADDR_COUNT, 32'h1);
        twop <= 1'b0;
    endtask
    task t_index;
        int p, j, k;
        wrr(`CPES_ADDR_RELOAD, 32'h50);
        for (p = 0; p < 4; p++) begin
            zen <= 1'b1;
            zph <= p[1:0];
            k = (p == 0) ? 4 : (p == 1) ? 3 : (p == 2) ? 1 : 2;
            arm(32'h43 | (p << 7));
            for (j = 0; j < 4; j++) step(1'b1);
            rck(`CPES_ADDR_COUNT, 32'h50 + 4 - k);
        end
        zen <= 1'b0;
    endtask
    task t_possamp;
        int g;
        for (g = 0; g < 2; g++) begin
            arm(32'h13 | (g << 9));
            step(1'b1);
            tick(1);
            step(1'b1);
            tick(1);
            rck(`CPES_ADDR_FIFO, 32'h1);
            rck(`CPES_ADDR_FIFO, 32'h2);
        end
        rck(`CPES_ADDR_FIFO, 32'h0);
    endtask
    task t_sep_one;
        int g, j;
        for (g = 0; g < 2; g++) begin
            arm(32'h5 | (g * 32'he00));
            tick(0);
            for (j = 0; j < 3; j++) tick(2);
            tick(0);
            tick(1);
            tick(0);
            tick(2);
            tick(1);
            rck(`CPES_ADDR_FIFO, 32'h3);
            rck(`CPES_ADDR_FIFO, 32'h0);
        end
    endtask
    task pop;
        @(posedge i_mclk);
        rdy <= 1'b1;
        @(posedge i_mclk);
        rdy <= 1'b0;
        @(negedge i_mclk);
    endtask
    task t_sep_imp;
        int j;
        arm(32'h2006);
        tick(0);
        for (j = 0; j < 2; j++) tick(2);
        tick(1);
        tick(1);
        tick(0);
        for (j = 0; j < 4; j++) tick(2);
        tick(1);
        @(negedge i_mclk);
        chk({31'h0, dv}, 32'h1);
        chk(ddat, 32'h2);
        pop;
        chk({31'h0, dv}, 32'h1);
        chk(ddat, 32'h4);
        pop;
        chk({31'h0, dv}, 32'h0);
    endtask
    // second pass: single mode with timed single point, falling sample edge
    task t_sep_smp;
        int g;
        for (g = 0; g < 2; g++) begin
            arm((g == 0) ? 32'h7 : 32'h1025);
            tick(0);
            tick(2);
            tick(2);
            tick(1);
            tick(3);
            rck(`CPES_ADDR_FIFO, 32'h2);
            tick(3);
            @(negedge i_mclk);
            chk({31'h0, ovr}, 32'h1);
            rck(`CPES_ADDR_STATUS, 32'h1005);
            wrr(`CPES_ADDR_STATUS, 32'h1);
            @(negedge i_mclk);
            chk({31'h0, ovr}, 32'h0);
        end
    endtask
    // reset, then each scenario in turn
    initial begin
        err_total = 0;
        check_count = 0;
        {i_rst_n, rd, wr, st, dr, twop, zen, rdy} = 8'h00;
        adr = 5'h0;
        wd = 32'h0;
        zph = 2'h0;
        pin = 4'h0;
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_regs;
        t_quad;
        t_index;
        t_possamp;
        t_sep_one;
        t_sep_imp;
        t_sep_smp;
        close_out;
    end
endmodule
`default_nettype wire
